// [rtl/aes_multimode.v]
// AES-256 engine with five chaining modes behind an AXI4-Lite register port
// How it works
// - AES-256 encrypt/decrypt, five modes, runtime selectable
// - key, IV, mode may change per block
// - input is plaintext or ciphertext per direction
// - codebook ignores IV, core alone
// - one shared core, modes differ in wiring
// - CBC decrypt runs core inverse
// - CFB/OFB/CTR decrypt run core forward
// - registers on AXI4-Lite, 32-bit data
// - 8-bit address space, unlisted reserved
// - write-only control at 0x00
// - read-only status at 0x04
// - top key word write commits key
// - top IV word write commits vector
// - top output read clears valid, data
// - status busy, valid, error; no busy load
`timescale 1ns/100ps
`include "aes_modes_consts.vh"
module aes_multimode
(
   input  wire        mclk,    // 125 MHz system clock
   input  wire        nrst,    // Async reset, active low
   input  wire [7:0]  awaddr,  // Write address
   input  wire        awvalid, // Write address valid
   output wire        awready, // Write address ready
   input  wire [31:0] wdata,   // Write data
   input  wire [3:0]  wstrb,   // Write byte strobes
   input  wire        wvalid,  // Write data valid
   output wire        wready,  // Write data ready
   output reg  [1:0]  bresp,   // Write response
   output reg         bvalid,  // Write response valid
   input  wire        bready,  // Write response ready
   input  wire [7:0]  araddr,  // Read address
   input  wire        arvalid, // Read address valid
   output wire        arready, // Read address ready
   output reg  [31:0] rdata,   // Read data
   output reg  [1:0]  rresp,   // Read response
   output reg         rvalid,  // Read data valid
   input  wire        rready   // Read data ready
);
   localparam IDLE = 2'd0;     // Waiting for work
   localparam KEYX = 2'd1;     // Expanding key
   localparam RUN  = 2'd2;     // Ciphering a block

   reg  [1:0]   st_r;          // Engine state
   reg          ctrlRst_r;     // Internal reset bit
   reg          dec_r;         // Decrypt selected
   reg  [2:0]   mode_r;        // Chaining mode
   reg  [2:0]   err_r;         // Error code
   reg          valid_r;       // Output valid
   reg  [255:0] keyBuf_r;      // Key words
   reg  [127:0] ivBuf_r;       // Vector words
   reg  [127:0] dinBuf_r;      // Input words
   reg  [127:0] dinRun_r;      // Block being ciphered
   reg  [127:0] dout_r;        // Output block
   reg  [127:0] init_vector;   // Chaining feedback value
   reg  [127:0] state_r;       // Core state
   reg  [127:0] kA_r;          // Older round key
   reg  [127:0] kB_r;          // Newer round key
   reg  [3:0]   rnd_r;         // Round counter
   reg  [3:0]   xIdx_r;        // Expansion index
   reg  [3:0]   rkIdx_r;       // Round key index
   reg  [2:0]   modeRun_r;     // Mode of running block
   reg          decRun_r;      // Direction of running block
   reg          coreInv_r;     // Core runs inverse
   reg  [3:0]   rkAddr;        // Key read index
   reg  [127:0] coreIn;        // Core input at start
   reg  [127:0] outN;          // Output at finish
   reg  [127:0] fbN;           // Feedback at finish
   wire [127:0] rkData;        // Round key from store
   wire [127:0] rndOut;        // One round result
   wire [127:0] expNext;       // Next expanded key
   wire [127:0] memWd;         // Key store data
   wire [7:0]   kOff;          // Key word offset
   wire [31:0]  wNew;          // Incoming top word
   wire         wrFire;        // Write taken
   wire         rdFire;        // Read taken
   wire         busy;          // Busy flag
   wire         running;       // Block in progress
   wire         lastRnd;       // Final round
   wire         modeOk;        // Mode code legal
   wire [127:0] ivNow;         // Vector with new top word
   wire [127:0] dinNow;        // Input with new top word
   wire [255:0] keyNow;        // Key with new top word
   wire         iv_load_strobe; // Vector commit
   wire         keyLoad;       // Key commit
   wire         blkStart;      // Block start request

   // Byte-strobed word merge
   function [31:0] merge;
      input [31:0] o;
      input [31:0] n;
      input [3:0]  s;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction

   // Multiply by x in GF(2^8)
   function [7:0] xt;
      input [7:0] a;
      xt = {a[6:0], 1'b0} ^ (a[7] ? `GF_POLY : 8'h00);
   endfunction

   // GF(2^8) multiply
   function [7:0] gm;
      input [7:0] a;
      input [7:0] b;
      reg   [7:0] p;
      reg   [7:0] x;
      integer i;
      begin
         p = 8'h00;
         x = a;
         for (i = 0; i < 8; i = i + 1)
         begin
            if (b[i])
               p = p ^ x;
            x = xt(x);
         end
         gm = p;
      end
   endfunction

   // Rotate byte left
   function [7:0] rl;
      input [7:0] v;
      input [2:0] n;
      reg   [15:0] d;
      begin
         d = {v, v} << n;
         rl = d[15:8];
      end
   endfunction

   // Forward or inverse S-box by field inversion and affine map
   function [7:0] sbox;
      input [7:0] b;
      input       inv;
      reg   [7:0] t;
      integer i;
      begin
         t = inv ? (rl(b, 3'd1) ^ rl(b, 3'd3) ^ rl(b, 3'd6) ^ `ISBOX_C) : b;
         sbox = t;
         for (i = 0; i < 6; i = i + 1)
            sbox = gm(gm(sbox, sbox), t);
         sbox = gm(sbox, sbox);
         if (!inv)
            sbox = sbox ^ rl(sbox, 3'd1) ^ rl(sbox, 3'd2) ^ rl(sbox, 3'd3)
                   ^ rl(sbox, 3'd4) ^ `SBOX_C;
      end
   endfunction

   // Mix or unmix columns
   function [127:0] mix;
      input [127:0] a;
      input         inv;
      reg   [7:0]   k;
      integer c, r, j;
      begin
         mix = 128'h0;
         for (c = 0; c < 4; c = c + 1)
            for (r = 0; r < 4; r = r + 1)
               for (j = 0; j < 4; j = j + 1)
               begin
                  case ((j - r + 4) % 4)
                     0:       k = inv ? 8'h0e : 8'h02;
                     1:       k = inv ? 8'h0b : 8'h03;
                     2:       k = inv ? 8'h0d : 8'h01;
                     default: k = inv ? 8'h09 : 8'h01;
                  endcase
                  mix[127-8*(r+4*c) -: 8] = mix[127-8*(r+4*c) -: 8]
                                           ^ gm(a[127-8*(j+4*c) -: 8], k);
               end
      end
   endfunction

   // One cipher round, forward or inverse
   function [127:0] round;
      input [127:0] s;
      input [127:0] k;
      input         inv;
      input         last;
      reg   [127:0] a;
      integer c, r, src;
      begin
         for (c = 0; c < 4; c = c + 1)
            for (r = 0; r < 4; r = r + 1)
            begin
               src = inv ? (c - r + 4) % 4 : (c + r) % 4;
               a[127-8*(r+4*c) -: 8] = sbox(s[127-8*(r+4*src) -: 8], inv);
            end
         if (inv)
            round = last ? (a ^ k) : mix(a ^ k, 1'b1);
         else
            round = (last ? a : mix(a, 1'b0)) ^ k;
      end
   endfunction

   // Next round key of the 256-bit schedule
   function [127:0] expand;
      input [127:0] ka;
      input [127:0] kb;
      input [3:0]   idx;
      reg   [31:0]  t;
      reg   [2:0]   rc;
      integer i;
      begin
         t = idx[0] ? kb[31:0] : {kb[23:0], kb[31:24]};
         for (i = 0; i < 4; i = i + 1)
            t[8*i +: 8] = sbox(t[8*i +: 8], 1'b0);
         rc = idx[3:1] - 3'd1;
         if (!idx[0])
            t[31:24] = t[31:24] ^ (8'h01 << rc);
         expand[127:96] = ka[127:96] ^ t;
         expand[95:64]  = ka[95:64] ^ expand[127:96];
         expand[63:32]  = ka[63:32] ^ expand[95:64];
         expand[31:0]   = ka[31:0] ^ expand[63:32];
      end
   endfunction

   assign wrFire  = awvalid & wvalid & ~bvalid;
   assign awready = wrFire;
   assign wready  = wrFire;
   assign rdFire  = arvalid & ~rvalid;
   assign arready = ~rvalid;

   assign running = (st_r == RUN);
   assign busy    = ctrlRst_r | (st_r != IDLE);
   assign lastRnd = (rnd_r == `RK_LAST);
   assign modeOk  = (wdata[2:0] <= `M_CTR);
   assign kOff    = awaddr - `A_KEY0;
   assign wNew    = merge(wdata, wdata, 4'hf);
   assign ivNow   = {merge(ivBuf_r[127:96], wNew, wstrb), ivBuf_r[95:0]};
   assign dinNow  = {merge(dinBuf_r[127:96], wNew, wstrb), dinBuf_r[95:0]};
   assign keyNow  = {merge(keyBuf_r[255:224], wNew, wstrb), keyBuf_r[223:0]};
   assign keyLoad = wrFire & (awaddr == `A_KEY7);
   assign iv_load_strobe = wrFire & (awaddr == `A_IV3);
   assign blkStart = wrFire & (awaddr == `A_DIN3);

   assign rndOut  = round(state_r, rkData, coreInv_r, lastRnd);
   assign expNext = expand(kA_r, kB_r, xIdx_r);
   assign memWd   = (xIdx_r == 4'h0) ? kA_r : ((xIdx_r == 4'h1) ? kB_r : expNext);

   // Round key fetch address, one cycle ahead
   always @*
   begin
      rkAddr = rkIdx_r;
      if (blkStart & ~busy)
      begin
         rkAddr = (dec_r & (mode_r <= `M_CBC)) ? `RK_LAST : `RK_FIRST;
      end
      else if (running)
         rkAddr = coreInv_r ? rkIdx_r - 4'h1 : rkIdx_r + 4'h1;
   end

   // Core input selection per mode
   always @*
   begin
      case (mode_r)
         `M_ECB:  coreIn = dinNow;
         `M_CBC:  coreIn = dec_r ? dinNow : dinNow ^ init_vector;
         // feedback modes cipher the feedback value
         default: coreIn = init_vector;
      endcase
   end

   // Output and next feedback per mode
   always @*
   begin
      outN = rndOut ^ dinRun_r;
      fbN  = init_vector;
      case (modeRun_r)
         `M_ECB: outN = rndOut;
         `M_CBC:
         begin
            outN = decRun_r ? rndOut ^ init_vector : rndOut;
            fbN  = decRun_r ? dinRun_r : rndOut;
         end
         `M_CFB: fbN = decRun_r ? dinRun_r : outN;
         `M_OFB: fbN = rndOut;
         `M_CTR: fbN = init_vector + 128'h1;
         default: fbN = init_vector;
      endcase
   end

   // Register file, key schedule and block engine
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= IDLE;
         ctrlRst_r <= `C_RST_INIT;
         dec_r <= 1'b0;
         mode_r <= `M_ECB;
         err_r <= `E_NONE;
         valid_r <= 1'b0;
         keyBuf_r <= 256'h0;
         ivBuf_r <= 128'h0;
         dinBuf_r <= 128'h0;
         dinRun_r <= 128'h0;
         dout_r <= 128'h0;
         init_vector <= 128'h0;
         state_r <= 128'h0;
         kA_r <= 128'h0;
         kB_r <= 128'h0;
         rnd_r <= 4'h0;
         xIdx_r <= 4'h0;
         rkIdx_r <= 4'h0;
         modeRun_r <= `M_ECB;
         decRun_r <= 1'b0;
         coreInv_r <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OK;
         rvalid <= 1'b0;
         rresp <= `RESP_OK;
         rdata <= 32'h0;
      end
      else
      begin
         rkIdx_r <= rkAddr;
         if (bvalid & bready)
            bvalid <= 1'b0;
         if (rvalid & rready)
            rvalid <= 1'b0;
         if (wrFire)
         begin
            bvalid <= 1'b1;
            bresp <= `RESP_OK;
            if (awaddr == `A_CTRL)
            begin
               ctrlRst_r <= wdata[`C_RST];
               dec_r <= wdata[`C_DEC];
               err_r <= `E_NONE;
               if (wdata[`C_SETM])
               begin
                  if (modeOk)
                     mode_r <= wdata[2:0];
                  else
                     err_r <= `E_MODE;
               end
            end
            else if (awaddr[1:0] == 2'b00 && awaddr >= `A_KEY0 && awaddr <= `A_KEY7)
               keyBuf_r[32*kOff[4:2] +: 32] <= merge(keyBuf_r[32*kOff[4:2] +: 32],
                                                    wdata, wstrb);
            else if ((awaddr & `WSEL_MASK) == `A_IV0)
               ivBuf_r[32*awaddr[3:2] +: 32] <= merge(ivBuf_r[32*awaddr[3:2] +: 32],
                                                     wdata, wstrb);
            else if ((awaddr & `WSEL_MASK) == `A_DIN0)
               dinBuf_r[32*awaddr[3:2] +: 32] <= merge(dinBuf_r[32*awaddr[3:2] +: 32],
                                                      wdata, wstrb);
            else
               bresp <= `RESP_ERR;
         end
         if (keyLoad)
         begin
            if (busy)
               err_r <= `E_KBUSY;
            else
            begin
               kA_r <= keyNow[255:128];
               kB_r <= keyNow[127:0];
               xIdx_r <= 4'h0;
               st_r <= KEYX;
            end
         end
         // feedback replaced by a new vector only when not busy
         if (iv_load_strobe)
         begin
            if (busy)
               err_r <= `E_KBUSY;
            else
               init_vector <= ivNow;
         end
         if (blkStart)
         begin
            if (busy)
               err_r <= `E_DBUSY;
            else
            begin
               dinRun_r <= dinNow;
               state_r <= coreIn;
               modeRun_r <= mode_r;
               decRun_r <= dec_r;
               coreInv_r <= dec_r & (mode_r <= `M_CBC);
               rnd_r <= 4'h0;
               st_r <= RUN;
            end
         end
         if (rdFire && araddr == `A_DOUT3)
         begin
            valid_r <= 1'b0;
            dout_r <= 128'h0;
         end
         case (st_r)
            KEYX:
            begin
               xIdx_r <= xIdx_r + 4'h1;
               if (xIdx_r >= 4'h2)
               begin
                  kA_r <= kB_r;
                  kB_r <= expNext;
               end
               if (xIdx_r == `RK_LAST)
                  st_r <= IDLE;
            end
            RUN:
            begin
               rnd_r <= rnd_r + 4'h1;
               state_r <= (rnd_r == 4'h0) ? state_r ^ rkData : rndOut;
               if (lastRnd)
               begin
                  dout_r <= outN;
                  init_vector <= fbN;
                  valid_r <= 1'b1;
                  st_r <= IDLE;
               end
            end
            // No hold here, so a commit or start above stands
            IDLE: ;
            default: st_r <= IDLE;
         endcase
         if (ctrlRst_r)
         begin
            st_r <= IDLE;
            valid_r <= 1'b0;
            dout_r <= 128'h0;
         end
         if (rdFire)
         begin
            rvalid <= 1'b1;
            rresp <= `RESP_OK;
            rdata <= 32'h0;
            if (araddr == `A_STAT)
               rdata <= {27'h0, err_r, valid_r, busy};
            else if ((araddr & `WSEL_MASK) == `A_DOUT0)
               rdata <= dout_r[32*araddr[3:2] +: 32];
            else
               rresp <= `RESP_ERR;
         end
      end
   end

   // Expanded round keys
   round_key_store u_rks
   (
      .mclk  (mclk),
      .nrst  (nrst),
      .we    (st_r == KEYX),
      .waddr (xIdx_r),
      .wdata (memWd),
      .raddr (rkAddr),
      .rdata (rkData)
   );
endmodule // aes_multimode

// [common/aes_modes_consts.vh]
// Address map, field positions, codes and counts of the cipher engine
`ifndef AES_MODES_CONSTS_VH
`define AES_MODES_CONSTS_VH
`define A_CTRL    8'h00
`define A_STAT    8'h04
`define A_KEY0    8'h10
`define A_KEY7    8'h2c
`define A_IV0     8'h30
`define A_IV3     8'h3c
`define A_DIN0    8'h40
`define A_DIN3    8'h4c
`define A_DOUT0   8'h50
`define A_DOUT3   8'h5c
`define WSEL_MASK 8'hf3
`define C_RST     5
`define C_DEC     4
`define C_SETM    3
`define C_RST_INIT 1'b1
`define M_ECB     3'h0
`define M_CBC     3'h1
`define M_CFB     3'h2
`define M_OFB     3'h3
`define M_CTR     3'h4
`define E_NONE    3'h0
`define E_MODE    3'h1
`define E_DBUSY   3'h2
`define E_KBUSY   3'h3
`define RESP_OK   2'h0
`define RESP_ERR  2'h2
`define RK_FIRST  4'h0
`define RK_LAST   4'he
`define SBOX_C    8'h63
`define ISBOX_C   8'h05
`define GF_POLY   8'h1b
`endif

// [rtl/round_key_store.v]
// Round key memory with registered read data
`timescale 1ns/100ps
module round_key_store
(
   input  wire         mclk,   // System clock
   input  wire         nrst,   // Async reset, active low
   input  wire         we,     // Write enable
   input  wire [3:0]   waddr,  // Write index
   input  wire [127:0] wdata,  // Round key to store
   input  wire [3:0]   raddr,  // Read index, sampled each edge
   output reg  [127:0] rdata   // Registered round key
);
   reg [127:0] mem [0:14];     // Fifteen round keys

   // Write port
   always @(posedge mclk)
   begin
      if (we)
         mem[waddr] <= wdata;
   end

   // Registered read port
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         rdata <= 128'h0;
      else
         rdata <= mem[raddr];
   end
endmodule // round_key_store

// [verification/aes_multimode_sva.sv]
// Register port checks of the cipher engine
`timescale 1ns/100ps
`include "aes_modes_consts.vh"
module aes_multimode_sva
(
   input logic        mclk,    // Clock
   input logic        nrst,    // Reset
   input logic [7:0]  awaddr,  // Wr addr
   input logic        awvalid, // Wr addr valid
   input logic        awready, // Wr addr ready
   input logic [31:0] wdata,   // Wr data
   input logic [3:0]  wstrb,   // Strobes
   input logic        wvalid,  // Wr data valid
   input logic        wready,  // Wr data ready
   input logic [1:0]  bresp,   // Wr resp
   input logic        bvalid,  // Wr resp valid
   input logic        bready,  // Wr resp ready
   input logic [7:0]  araddr,  // Rd addr
   input logic        arvalid, // Rd addr valid
   input logic        arready, // Rd addr ready
   input logic [31:0] rdata,   // Rd data
   input logic [1:0]  rresp,   // Rd resp
   input logic        rvalid,  // Rd valid
   input logic        rready   // Rd ready
);
   wire wTake = awvalid && wvalid && !bvalid; // Write taken
   wire rTake = arvalid && !rvalid;           // Read taken
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_wrAns; wTake |=> bvalid; endproperty
   a_wrAns: assert property (p_wrAns) else $error("write not answered");
   property p_wrRdy; awready == wTake && wready == wTake; endproperty
   a_wrRdy: assert property (p_wrRdy) else $error("write ready wrong");
   property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bHold: assert property (p_bHold) else $error("write resp dropped");
   property p_bDone; bvalid && bready |=> !bvalid; endproperty
   a_bDone: assert property (p_bDone) else $error("write resp stuck");
   property p_rdAns; rTake |=> rvalid; endproperty
   a_rdAns: assert property (p_rdAns) else $error("read not answered");
   property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
   a_rHold: assert property (p_rHold) else $error("read data dropped");
   property p_rdRdy; arready == !rvalid; endproperty
   a_rdRdy: assert property (p_rdRdy) else $error("read ready wrong");
   property p_badRd; rTake && (araddr == `A_CTRL || araddr == 8'h08)
      |=> rresp == `RESP_ERR && rdata == 32'h0; endproperty
   a_badRd: assert property (p_badRd) else $error("bad read accepted");
   property p_badWr; wTake && (awaddr == `A_STAT || awaddr == `A_DOUT3)
      |=> bresp == `RESP_ERR; endproperty
   a_badWr: assert property (p_badWr) else $error("bad write accepted");
   property p_stRd; rTake && araddr == `A_STAT
      |=> rresp == `RESP_OK && rdata[31:5] == 27'h0; endproperty
   a_stRd: assert property (p_stRd) else $error("status read wrong");
endmodule // aes_multimode_sva
bind aes_multimode aes_multimode_sva chk
(
   .mclk(mclk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
   .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
   .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);

// [verification/axil_master_model.sv]
// Register bus master driving the engine port
`timescale 1ns/100ps
module axil_master_model
(
   input  logic        mclk,    // Clock
   output logic [7:0]  awaddr,  // Wr addr
   output logic        awvalid, // Wr addr valid
   input  logic        awready, // Wr addr ready
   output logic [31:0] wdata,   // Wr data
   output logic [3:0]  wstrb,   // Strobes
   output logic        wvalid,  // Wr data valid
   input  logic        wready,  // Wr data ready
   input  logic [1:0]  bresp,   // Wr resp
   input  logic        bvalid,  // Wr resp valid
   output logic        bready,  // Wr resp ready
   output logic [7:0]  araddr,  // Rd addr
   output logic        arvalid, // Rd addr valid
   input  logic        arready, // Rd addr ready
   input  logic [31:0] rdata,   // Rd data
   input  logic [1:0]  rresp,   // Rd resp
   input  logic        rvalid,  // Rd valid
   output logic        rready   // Rd ready
);
   int n;         // Wait bound
   int stall = 0; // Response accept delay
   int tmo = 0;   // Waits that ran out
   // Idle bus from time zero
   initial
      {awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
   // one 32-bit write, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(negedge mclk);
      {awaddr, wdata, wstrb, awvalid, wvalid} = {a, d, 4'hf, 2'b11};
      n = 0;
      do @(posedge mclk); while (!(awready && wready) && (n++ < 50 || tmo++ < 0));
      @(negedge mclk);
      {awaddr, wdata, awvalid, wvalid} = {~a, ~d, 2'b00};
      repeat (stall) @(negedge mclk);
      bready = 1;
      n = 0;
      do @(posedge mclk); while (!bvalid && (n++ < 50 || tmo++ < 0));
      r = bresp;
      @(negedge mclk);
      bready = 0;
   endtask
   // one 32-bit read, held until taken
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(negedge mclk);
      {araddr, arvalid} = {a, 1'b1};
      n = 0;
      do @(posedge mclk); while (!arready && (n++ < 50 || tmo++ < 0));
      @(negedge mclk);
      {araddr, arvalid} = {~a, 1'b0};
      repeat (stall) @(negedge mclk);
      rready = 1;
      n = 0;
      do @(posedge mclk); while (!rvalid && (n++ < 50 || tmo++ < 0));
      {d, r} = {rdata, rresp};
      @(negedge mclk);
      rready = 0;
   endtask
endmodule // axil_master_model

// [verification/aes_multimode_tb_top.sv]
// Self-checking bench of the cipher engine
`timescale 1ns/100ps
`include "aes_modes_consts.vh"
module aes_multimode_tb_top;
   // Known-answer key and block pair
   localparam logic [255:0] KEY = {128'h000102030405060708090a0b0c0d0e0f,
                                   128'h101112131415161718191a1b1c1d1e1f};
   localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
   localparam logic [127:0] CT  = 128'h8ea2b7ca516745bfeafc49904b496089;
   logic         mclk = 0;        // Clock
   logic         nrst = 0;        // Reset
   logic [7:0]   awaddr, araddr;  // Addresses
   logic [31:0]  wdata, rdata, v; // Words
   logic [3:0]   wstrb;           // Strobes
   logic [1:0]   bresp, rresp, r; // Responses
   logic         awvalid, awready, wvalid, wready, bvalid, bready; // Write handshake
   logic         arvalid, arready, rvalid, rready;                 // Read handshake
   logic [31:0]  seed = 32'h3;    // Random state
   logic [127:0] d, o, e;         // Blocks
   int           fails = 0;       // Mismatches
   int           check_count = 0; // Comparisons
   aes_multimode dut
   (
      .mclk(mclk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   axil_master_model m
   (
      .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   // Free-running clock
   initial
      forever #4 mclk = ~mclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Next random block
   task automatic rnd(output logic [127:0] x);
      repeat (4)
      begin
         seed = lfsr(seed);
         x = {x[95:0], seed};
      end
   endtask
   // Compare a word
   task automatic chkV(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // Compare a block
   task automatic chkB(input string n, input logic [127:0] x, input logic [127:0] g);
      check_count++;
      if (g !== x)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // Read and compare status
   task automatic stat(input logic [31:0] x);
      m.rd(`A_STAT, v, r);
      chkV("status", x, v);
   endtask
   // Write words upward, top word last
   task automatic ld(input logic [7:0] b, input logic [255:0] x, input int nw);
      for (int i = 0; i < nw; i++)
         m.wr(b + 8'(4 * i), x[32 * i +: 32], r);
   endtask
   // Read the output block, top word last
   task automatic rdo(output logic [127:0] y);
      for (int i = 0; i < 4; i++)
         m.rd(`A_DOUT0 + 8'(4 * i), y[32 * i +: 32], r);
   endtask
   // One block with busy, valid and clear observed
   task automatic run(input logic [2:0] md, input logic dc, input logic ni,
                      input logic [127:0] iv, input logic [127:0] x, output logic [127:0] y);
      m.wr(`A_CTRL, {27'h0, dc, 1'b1, md}, r);
      if (ni)
         ld(`A_IV0, {128'h0, iv}, 4);
      ld(`A_DIN0, {128'h0, x}, 4);
      stat(32'h1);
      repeat (20) @(negedge mclk);
      stat(32'h2);
      rdo(y);
      stat(32'h0);
   endtask
   // Closing verdict
   task automatic tally_and_finish;
      fails += m.tmo;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      #200000;
      fails++;
      tally_and_finish;
   end
   // Main sequence
   initial
   begin
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      nrst = 1;
      stat(32'h1);
      m.wr(`A_CTRL, 32'h0, r);
      stat(32'h0);
      m.rd(`A_CTRL, v, r);
      chkV("control read resp", 32'h2, {30'h0, r});
      m.rd(8'h08, v, r);
      chkV("reserved read", 32'h0, v);
      m.wr(`A_STAT, 32'h3, r);
      chkV("status write resp", 32'h2, {30'h0, r});
      m.wr(`A_DOUT3, 32'h0, r);
      chkV("output write resp", 32'h2, {30'h0, r});
      $display("test registers done");
      ld(`A_KEY0, KEY, 8);
      stat(32'h1);
      m.wr(`A_KEY7, KEY[255:224], r);
      stat(32'hd);
      repeat (20) @(negedge mclk);
      m.wr(`A_KEY7, KEY[255:224], r);
      repeat (20) @(negedge mclk);
      stat(32'hc);
      $display("test key done");
      for (int md = 0; md < 5; md++)
         for (int dc = 0; dc < 2; dc++)
         begin
            rnd(d);
            m.stall = int'(d[1:0]);
            run(3'(md), 1'(dc), 1'b1, (md == 1 && dc == 0) ? PT ^ d : (md < 2 ? d : PT),
                md == 0 ? (dc ? CT : PT) : (md == 1 && dc ? CT : d), o);
            e = md == 0 ? (dc ? PT : CT) : (md == 1 ? (dc ? PT ^ d : CT) : CT ^ d);
            chkB("block", e, o);
            $display("test mode %0d dir %0d done", md, dc);
         end
      m.wr(`A_CTRL, {27'h0, 1'b0, 1'b1, `M_ECB}, r);
      ld(`A_DIN0, {128'h0, PT}, 4);
      m.wr(`A_DIN3, 32'h0, r);
      stat(32'h9);
      repeat (20) @(negedge mclk);
      rdo(o);
      chkB("busy block", CT, o);
      m.wr(`A_CTRL, 32'hd, r);
      stat(32'h4);
      $display("test errors done");
      rnd(d);
      run(`M_CBC, 1'b1, 1'b1, d, d, o);
      run(`M_CBC, 1'b1, 1'b0, 128'h0, CT, o);
      chkB("cbc chain", PT ^ d, o);
      run(`M_CTR, 1'b0, 1'b1, PT - 128'h1, d, o);
      run(`M_CTR, 1'b0, 1'b0, 128'h0, d, o);
      chkB("ctr chain", CT ^ d, o);
      run(`M_CFB, 1'b1, 1'b1, d, PT, o);
      run(`M_CFB, 1'b1, 1'b0, 128'h0, d, o);
      chkB("cfb chain", CT ^ d, o);
      $display("test chaining done");
      rnd(e);
      rnd(d);
      ld(`A_KEY0, {e, d}, 8);
      repeat (20) @(negedge mclk);
      run(`M_ECB, 1'b0, 1'b1, 128'h0, d, o);
      run(`M_ECB, 1'b1, 1'b0, 128'h0, o, e);
      chkB("roundtrip", d, e);
      $display("test new key done");
      tally_and_finish;
   end
endmodule // aes_multimode_tb_top
